// ==== logic/acds_defines.svh ====
// Register indexes, field positions, reset values and timing constants
`ifndef ACDS_DEFINES_SVH
`define ACDS_DEFINES_SVH

`define ACDS_IDX_DMA_SEL    8'h09
`define ACDS_IDX_CAL_SEL    8'h17
`define ACDS_IDX_TRIM_LOAD  8'h20
`define ACDS_IDX_STATUS     8'h21

`define ACDS_DMA_LSB        4
`define ACDS_DMA_MSB        7
`define ACDS_REF_LSB        8
`define ACDS_REF_MSB        11
`define ACDS_DAC_LSB        0
`define ACDS_DAC_MSB        2
`define ACDS_TRIM_DATA_LSB  0
`define ACDS_TRIM_DATA_MSB  7
`define ACDS_TRIM_ADDR_LSB  8
`define ACDS_TRIM_ADDR_MSB  11
`define ACDS_TRIM_ALT_BIT   16
`define ACDS_STAT_BUSY_BIT  0
`define ACDS_STAT_ALT_BIT   1

`define ACDS_REF_INTERNAL   4'h0
`define ACDS_REF_GROUND     4'h1
`define ACDS_REF_CH_FIRST   4'h2
`define ACDS_REF_CH_LAST    4'h9

`define ACDS_DMA_RESET      4'h0
`define ACDS_REF_RESET      4'h0
`define ACDS_DAC_RESET      3'h0

`define ACDS_FRAME_BITS     12
`define ACDS_CORE_CLK_MHZ   100
`define ACDS_TRIM_HALF_NS   50

`endif

// ==== logic/acds_pkg.sv ====
// Types shared by the calibration and DMA select register bank
package acds_pkg;

  typedef struct packed {
    logic [3:0] ref_code;
    logic [2:0] dac_num;
  } acds_cal_sel_type;

  typedef struct packed {
    logic       ref_valid;
    logic       ref_internal;
    logic       ref_ground;
    logic [7:0] ref_channel;
    logic [7:0] dac_onehot;
  } acds_cal_decode_type;

  typedef enum logic [1:0] {
    ACDS_ST_IDLE  = 2'b00,
    ACDS_ST_SHIFT = 2'b01,
    ACDS_ST_LATCH = 2'b10
  } acds_trim_state_type;

endpackage : acds_pkg

// ==== logic/acds_regs.sv ====
// APB register bank: calibration select, AO DMA select, trim serial loader
//
// Contract
// RULE_01: Software writes zero to reserved bits; the bank ignores them.
// RULE_02: Reference code 0 internal, 1 ground, 2..9 output channel 0..7.
// RULE_03: Three-bit binary channel number selects the DAC under calibration.
// RULE_04: Upper four bits enable DMA channels A..D; lower bits reserved.
// RULE_05: DMA select register clears at power-up and on every reset.
// RULE_06: Software sets DMA select bits before enabling that DMA channel.
// RULE_07: Alternate trim converter gets address MSB first: A3,A2,A1,A0.
// RULE_08: Reference codes 10..15 are reserved and select no reference.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "acds_defines.svh"

module acds_regs
  import acds_pkg::*;
#(
  parameter int ADDR_W  = 8,
  parameter int HALF_CY = (`ACDS_TRIM_HALF_NS * `ACDS_CORE_CLK_MHZ) / 1000
) (
  input  wire logic                I_CORE_CLK,
  input  wire logic                I_RST_N,
  input  wire logic                I_PSEL,
  input  wire logic                I_PENABLE,
  input  wire logic                I_PWRITE,
  input  wire logic [ADDR_W-1:0]   I_PADDR,
  input  wire logic [31:0]         I_PWDATA,
  output      logic [31:0]         O_PRDATA,
  output      logic                O_PREADY,
  output      logic                O_PSLVERR,
  output      acds_cal_sel_type    O_CAL_SEL,
  output      acds_cal_decode_type O_CAL_DECODE,
  output      logic [3:0]          O_DMA_CH_EN,
  output      logic                O_TRIM_SCLK,
  output      logic                O_TRIM_SDATA,
  output      logic                O_TRIM_LOAD_N
);

  localparam int HC = (HALF_CY < 1) ? 1 : HALF_CY;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction : byte_addr

  // RULE_07 address order
  function automatic logic [`ACDS_FRAME_BITS-1:0] build_frame(
    input logic [3:0] addr,
    input logic [7:0] data,
    input logic       alt
  );
    if (alt) begin
      build_frame = {addr[3], addr[2], addr[1], addr[0], data};
    end else begin
      build_frame = {addr[0], addr[1], addr[2], addr[3], data};
    end
  endfunction : build_frame

  logic                  access;
  logic                  wr_en;
  logic                  rd_hit;
  logic                  mapped;
  logic                  busy;
  logic                  trim_wr;
  logic [3:0]            dma_r;
  acds_cal_sel_type      cal_r;
  acds_trim_state_type   st_r;
  logic [`ACDS_FRAME_BITS-1:0] sh_r;
  logic [3:0]            bit_r;
  logic [15:0]           div_r;
  logic                  half_r;
  logic                  alt_r;
  logic [31:0]           rdata_r;

  assign access  = I_PSEL && I_PENABLE;
  assign mapped  = (I_PADDR == byte_addr(`ACDS_IDX_DMA_SEL))
                || (I_PADDR == byte_addr(`ACDS_IDX_CAL_SEL))
                || (I_PADDR == byte_addr(`ACDS_IDX_TRIM_LOAD))
                || (I_PADDR == byte_addr(`ACDS_IDX_STATUS));
  assign busy    = (st_r != ACDS_ST_IDLE);
  assign trim_wr = access && I_PWRITE
                && (I_PADDR == byte_addr(`ACDS_IDX_TRIM_LOAD));
  // Trim load while a frame is in flight would corrupt it
  assign wr_en   = access && I_PWRITE && mapped && !(trim_wr && busy);
  assign rd_hit  = access && !I_PWRITE
                && (I_PADDR == byte_addr(`ACDS_IDX_STATUS));

  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = access && (!mapped || (trim_wr && busy));
  assign O_PRDATA  = rdata_r;

  // RULE_05 cleared on reset
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      dma_r <= `ACDS_DMA_RESET;
    end else if (wr_en && I_PADDR == byte_addr(`ACDS_IDX_DMA_SEL)) begin
      // RULE_04 upper bits only
      dma_r <= I_PWDATA[`ACDS_DMA_MSB:`ACDS_DMA_LSB];
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cal_r.ref_code <= `ACDS_REF_RESET;
      cal_r.dac_num  <= `ACDS_DAC_RESET;
    end else if (wr_en && I_PADDR == byte_addr(`ACDS_IDX_CAL_SEL)) begin
      // RULE_01 reserved bits dropped
      cal_r.ref_code <= I_PWDATA[`ACDS_REF_MSB:`ACDS_REF_LSB];
      cal_r.dac_num  <= I_PWDATA[`ACDS_DAC_MSB:`ACDS_DAC_LSB];
    end
  end

  // Status is the only readable word; write-only registers read zero
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= 32'h0000_0000;
      if (I_PSEL && !I_PENABLE && !I_PWRITE
          && I_PADDR == byte_addr(`ACDS_IDX_STATUS)) begin
        rdata_r[`ACDS_STAT_BUSY_BIT] <= busy;
        rdata_r[`ACDS_STAT_ALT_BIT]  <= alt_r;
      end else if (rd_hit) begin
        rdata_r <= rdata_r;
      end
    end
  end

  assign O_CAL_SEL   = cal_r;
  assign O_DMA_CH_EN = dma_r;

  // RULE_02 reference decode
  // RULE_08 reserved codes select nothing
  always_comb begin
    O_CAL_DECODE.ref_valid    = (cal_r.ref_code <= `ACDS_REF_CH_LAST);
    O_CAL_DECODE.ref_internal = (cal_r.ref_code == `ACDS_REF_INTERNAL);
    O_CAL_DECODE.ref_ground   = (cal_r.ref_code == `ACDS_REF_GROUND);
    O_CAL_DECODE.ref_channel  = 8'h00;
    if (cal_r.ref_code >= `ACDS_REF_CH_FIRST
        && cal_r.ref_code <= `ACDS_REF_CH_LAST) begin
      O_CAL_DECODE.ref_channel =
        8'(8'h01 << (cal_r.ref_code - `ACDS_REF_CH_FIRST));
    end
    // RULE_03 binary channel number
    O_CAL_DECODE.dac_onehot = 8'(8'h01 << cal_r.dac_num);
  end

  // Serial trim loader: data set on low half, sampled on rising sclk
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_r   <= ACDS_ST_IDLE;
      sh_r   <= '0;
      bit_r  <= 4'h0;
      div_r  <= 16'h0000;
      half_r <= 1'b0;
      alt_r  <= 1'b0;
    end else begin
      case (st_r)
        ACDS_ST_IDLE: begin
          half_r <= 1'b0;
          div_r  <= 16'h0000;
          bit_r  <= 4'h0;
          if (wr_en && trim_wr) begin
            alt_r <= I_PWDATA[`ACDS_TRIM_ALT_BIT];
            sh_r  <= build_frame(
              I_PWDATA[`ACDS_TRIM_ADDR_MSB:`ACDS_TRIM_ADDR_LSB],
              I_PWDATA[`ACDS_TRIM_DATA_MSB:`ACDS_TRIM_DATA_LSB],
              I_PWDATA[`ACDS_TRIM_ALT_BIT]);
            st_r  <= ACDS_ST_SHIFT;
          end
        end
        ACDS_ST_SHIFT: begin
          if (div_r == 16'(HC - 1)) begin
            div_r  <= 16'h0000;
            half_r <= !half_r;
            if (half_r) begin
              sh_r  <= {sh_r[`ACDS_FRAME_BITS-2:0], 1'b0};
              bit_r <= 4'(bit_r + 4'h1);
              if (bit_r == 4'(`ACDS_FRAME_BITS - 1)) begin
                st_r <= ACDS_ST_LATCH;
              end
            end
          end else begin
            div_r <= 16'(div_r + 16'h0001);
          end
        end
        ACDS_ST_LATCH: begin
          if (div_r == 16'(HC - 1)) begin
            div_r <= 16'h0000;
            st_r  <= ACDS_ST_IDLE;
          end else begin
            div_r <= 16'(div_r + 16'h0001);
          end
        end
        default: begin
          st_r <= ACDS_ST_IDLE;
        end
      endcase
    end
  end

  assign O_TRIM_SCLK   = (st_r == ACDS_ST_SHIFT) && half_r;
  assign O_TRIM_SDATA  = (st_r == ACDS_ST_SHIFT) && sh_r[`ACDS_FRAME_BITS-1];
  assign O_TRIM_LOAD_N = (st_r != ACDS_ST_LATCH);

  // Checks
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  property p_dma_write;
    wr_en && I_PADDR == byte_addr(`ACDS_IDX_DMA_SEL)
      |=> O_DMA_CH_EN == $past(I_PWDATA[`ACDS_DMA_MSB:`ACDS_DMA_LSB]);
  endproperty
  a_dma_write: assert property (p_dma_write) // RULE_04
    else $error("DMA select did not take upper write bits");

  property p_dma_reset;
    $rose(I_RST_N) |-> O_DMA_CH_EN == 4'h0;
  endproperty
  a_dma_reset: assert property (@(posedge I_CORE_CLK) p_dma_reset) // RULE_05
    else $error("DMA select not clear after reset");

  property p_dac_sel;
    wr_en && I_PADDR == byte_addr(`ACDS_IDX_CAL_SEL)
      |=> O_CAL_DECODE.dac_onehot
        == 8'(8'h01 << $past(I_PWDATA[`ACDS_DAC_MSB:`ACDS_DAC_LSB]));
  endproperty
  a_dac_sel: assert property (p_dac_sel) // RULE_03
    else $error("DAC select does not follow written number");

  property p_ref_ch;
    O_CAL_SEL.ref_code == 4'h3 |-> O_CAL_DECODE.ref_channel == 8'h02
      && !O_CAL_DECODE.ref_internal && !O_CAL_DECODE.ref_ground;
  endproperty
  a_ref_ch: assert property (p_ref_ch) // RULE_02
    else $error("Reference code 3 must pick channel 1");

  property p_ref_rsvd;
    O_CAL_SEL.ref_code > `ACDS_REF_CH_LAST
      |-> !O_CAL_DECODE.ref_valid && O_CAL_DECODE.ref_channel == 8'h00;
  endproperty
  a_ref_rsvd: assert property (p_ref_rsvd) // RULE_08
    else $error("Reserved reference code selected something");

  property p_rsvd_ignored;
    wr_en && I_PADDR == byte_addr(`ACDS_IDX_CAL_SEL)
      |=> O_CAL_SEL == {$past(I_PWDATA[`ACDS_REF_MSB:`ACDS_REF_LSB]),
                        $past(I_PWDATA[`ACDS_DAC_MSB:`ACDS_DAC_LSB])};
  endproperty
  a_rsvd_ignored: assert property (p_rsvd_ignored) // RULE_01
    else $error("Calibration select took reserved bits");

  property p_first_bit;
    $rose(st_r == ACDS_ST_SHIFT) |-> O_TRIM_SDATA ==
      ($past(I_PWDATA[`ACDS_TRIM_ALT_BIT])
        ? $past(I_PWDATA[`ACDS_TRIM_ADDR_MSB])
        : $past(I_PWDATA[`ACDS_TRIM_ADDR_LSB]));
  endproperty
  a_first_bit: assert property (p_first_bit) // RULE_07
    else $error("First trim bit has wrong address order");

  c_dma: cover property (wr_en && I_PADDR == byte_addr(`ACDS_IDX_DMA_SEL));
  c_alt: cover property ($rose(st_r == ACDS_ST_SHIFT) && alt_r);
  c_latch: cover property ($fell(O_TRIM_LOAD_N));
  c_refused: cover property (trim_wr && busy);

endmodule : acds_regs

// ==== test/acds_trim_model.sv ====
// Behavioural trim converter that captures serial frames
`timescale 1ns/1ps
module acds_trim_model (
  input  wire logic        i_sclk,
  input  wire logic        i_sdata,
  input  wire logic        i_load_n,
  output      logic [11:0] o_frame,
  output      logic [4:0]  o_bits,
  output      logic        o_done
);
  logic [11:0] sh_r = 12'h000;
  logic [4:0]  cnt_r = 5'h00;
  initial o_done = 1'b0;
  always @(posedge i_sclk) begin
    sh_r = {sh_r[10:0], i_sdata};
    cnt_r = cnt_r + 5'h01;
  end
  // Latch strobe ends the frame
  always @(negedge i_load_n) begin
    o_frame = sh_r;
    o_bits = cnt_r;
    cnt_r = 5'h00;
    o_done = 1'b1;
    #1 o_done = 1'b0;
  end
endmodule : acds_trim_model

// ==== test/acds_regs_tb_top.sv ====
// Self-checking bench for the calibration and DMA select bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module acds_regs_tb_top;
  import acds_pkg::*;
  localparam int HC = 2;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, sclk, sdata, load_n, done;
  acds_cal_sel_type cal_sel;
  acds_cal_decode_type cal_dec, xd;
  logic [3:0] dma_en, a, d4;
  logic [7:0] d;
  logic [2:0] dac;
  logic [11:0] frame, xf;
  logic [4:0] bits;
  logic [11:0] q[$];
  int bad_count = 0, checks = 0, cyc = 0;
  acds_regs #(.HALF_CY(HC)) DUT (.I_CORE_CLK(clk), .I_RST_N(rst_n),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .O_CAL_SEL(cal_sel),
    .O_CAL_DECODE(cal_dec), .O_DMA_CH_EN(dma_en), .O_TRIM_SCLK(sclk),
    .O_TRIM_SDATA(sdata), .O_TRIM_LOAD_N(load_n));
  acds_trim_model TRIM (.i_sclk(sclk), .i_sdata(sdata),
    .i_load_n(load_n), .o_frame(frame), .o_bits(bits), .o_done(done));
  always #5 clk = ~clk;
  task automatic test_done;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Frames are judged as the converter latches them
  always @(posedge done) begin
    xf = q.size() ? q.pop_front() : 12'hxxx;
    `CHK("bits", 5'h0c, bits)
    `CHK("frame", xf, frame)
  end
  initial begin
    void'($urandom(25311));
    repeat (15) @(posedge clk);
    #1 `CHK("dma_rst", 4'h0, dma_en)
    `CHK("load_idle", 1'b1, load_n)
    // Release on a rising edge, like every other input
    @(posedge clk);
    rst_n <= 1'b1;
    // Reserved bits kept zero by software; every reference code tried
    for (int r = 0; r < 16; r++) begin
      dac = 3'($urandom);
      apb(1'b1, 8'h5c, {20'h0, 4'(r), 5'h00, dac});
      @(posedge clk);
      #1;
      xd.ref_valid = (r < 10);
      xd.ref_internal = (r == 0);
      xd.ref_ground = (r == 1);
      xd.ref_channel = (r >= 2 && r <= 9) ? 8'(1 << (r - 2)) : 8'h00;
      xd.dac_onehot = 8'(1 << dac);
      `CHK("cal_sel", {4'(r), dac}, cal_sel)
      `CHK("cal_dec", xd, cal_dec)
    end
    $display("test cal_select done");
    // Selection set before any channel would be enabled
    repeat (4) begin
      d4 = 4'($urandom);
      apb(1'b1, 8'h24, {24'h0, d4, 4'($urandom)});
      @(posedge clk);
      #1 `CHK("dma_en", d4, dma_en)
    end
    apb(1'b0, 8'h24, 32'h0);
    `CHK("wo_read", 32'h0, rd)
    apb(1'b1, 8'h40, 32'hffffffff);
    `CHK("unmapped", 1'b1, err)
    `CHK("dma_keep", d4, dma_en)
    $display("test dma_select done");
    for (int k = 0; k < 2; k++) begin
      a = 4'($urandom);
      d = 8'($urandom);
      q.push_back(k ? {a, d} : {a[0], a[1], a[2], a[3], d});
      apb(1'b1, 8'h80, {15'h0, 1'(k), 4'h0, a, d});
      apb(1'b1, 8'h80, 32'h0);
      `CHK("busy_err", 1'b1, err)
      do apb(1'b0, 8'h84, 32'h0); while (rd[0] !== 1'b0);
      `CHK("alt", 1'(k), rd[1])
    end
    `CHK("frames", 0, q.size())
    $display("test trim_load done");
    // Mid-run reset must clear a non-zero DMA selection
    apb(1'b1, 8'h24, 32'h0000_00f0);
    @(posedge clk);
    #1 `CHK("dma_pre", 4'hf, dma_en)
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1 `CHK("dma_rst2", 4'h0, dma_en)
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 `CHK("dma_rel", 4'h0, dma_en)
    apb(1'b1, 8'h24, 32'h0000_0050);
    @(posedge clk);
    #1 `CHK("dma_again", 4'h5, dma_en)
    $display("test reset done");
    test_done();
  end
endmodule : acds_regs_tb_top
